/* logic/lbd_pkg.sv */
// Shared constants, codes and decode functions of the LED brightness and dimming block.
package lbd_pkg;

	// ==========================================================================
	// Clock, widths and counts
	// ==========================================================================
	localparam int unsigned CLK_HZ          = 125_000_000;
	localparam int unsigned CHANNELS        = 6;
	localparam int unsigned DUTY_W          = 16;
	localparam int unsigned CURRENT_W       = 12;
	localparam int unsigned WINDOW_LOG2_DEF = 16;

	// ==========================================================================
	// Mode and field codes
	// ==========================================================================
	localparam logic [1:0]  SRC_INPUT          = 2'h0;
	localparam logic [1:0]  SRC_INPUT_X_LEVEL  = 2'h1;
	localparam logic [1:0]  SRC_LEVEL          = 2'h2;
	localparam logic [1:0]  SRC_SHAPED_X_LEVEL = 2'h3;
	localparam logic [1:0]  DIM_PWM_ONLY       = 2'h0;
	localparam logic [1:0]  DIM_CURRENT_ONLY   = 2'h1;
	localparam logic [11:0] FINE_FULL          = 12'hFFF;
	localparam logic [7:0]  RESISTOR_NOMINAL   = 8'h80;
	localparam logic [6:0]  PCT_FULL           = 7'h64;
	localparam logic [4:0]  ROW_FLOATING       = 5'h00;
	localparam logic [4:0]  ROW_FOLLOW_INPUT   = 5'h19;
	localparam logic [15:0] DUTY_FULL          = 16'hFFFF;
	localparam logic [15:0] UA_PER_MA          = 16'h03E8;

	// ==========================================================================
	// Decode functions
	// ==========================================================================
	// Rate word layout: resolution in [19:16], frequency in Hz in [15:0].
	function automatic logic [19:0] lbd_rate_from_code(input logic [3:0] code);
		unique case (code)
			4'h0: return {4'hB, 16'd4808};
			4'h1: return {4'hA, 16'd6010};
			4'h2: return {4'hA, 16'd7212};
			4'h3: return {4'hA, 16'd8414};
			4'h4: return {4'hA, 16'd9616};
			4'h5: return {4'h9, 16'd12020};
			4'h6: return {4'h9, 16'd13222};
			4'h7: return {4'h9, 16'd14424};
			4'h8: return {4'h9, 16'd15626};
			4'h9: return {4'h9, 16'd16828};
			4'hA: return {4'h9, 16'd18030};
			4'hB: return {4'h9, 16'd19232};
			4'hC: return {4'h8, 16'd24040};
			4'hD: return {4'h8, 16'd28848};
			4'hE: return {4'h8, 16'd33656};
			4'hF: return {4'h8, 16'd38464};
		endcase
	endfunction : lbd_rate_from_code

	// The resistor rows repeat one set of eight rates for each boost frequency group.
	function automatic logic [19:0] lbd_rate_from_resistor(input logic [4:0] row);
		logic [4:0] idx;
		idx = 5'(row - 5'h01);
		if (row == ROW_FLOATING || row > ROW_FOLLOW_INPUT) return {4'hA, 16'd9616};
		if (row == ROW_FOLLOW_INPUT) return {4'hA, 16'd9616};
		unique case (5'(idx % 5'h08))
			5'h00:   return {4'hC, 16'd2402};
			5'h01:   return {4'hB, 16'd4808};
			5'h02:   return {4'hA, 16'd6010};
			5'h03:   return {4'hA, 16'd9616};
			5'h04:   return {4'h9, 16'd12020};
			5'h05:   return {4'h9, 16'd14424};
			5'h06:   return {4'h9, 16'd16828};
			default: return {4'h9, 16'd19232};
		endcase
	endfunction : lbd_rate_from_resistor

	function automatic logic [5:0] lbd_range_ma(input logic [2:0] code);
		unique case (code)
			3'h0: return 6'd5;
			3'h1: return 6'd10;
			3'h2: return 6'd15;
			3'h3: return 6'd20;
			3'h4: return 6'd23;
			3'h5: return 6'd25;
			3'h6: return 6'd30;
			3'h7: return 6'd50;
		endcase
	endfunction : lbd_range_ma

	// Level 8'hFF maps to just under unity (65535/65536) because {l,l} equals l times 257.
	function automatic logic [15:0] lbd_scale_by_level(input logic [15:0] d, input logic [7:0] l);
		logic [31:0] p;
		p = 32'(d) * 32'({l, l});
		return p[31:16];
	endfunction : lbd_scale_by_level

	function automatic logic [15:0] lbd_pct_to_level(input logic [6:0] pct);
		logic [31:0] p;
		p = 32'((pct > PCT_FULL) ? PCT_FULL : pct) * 32'(DUTY_FULL);
		return 16'(p / 32'(PCT_FULL));
	endfunction : lbd_pct_to_level

endpackage : lbd_pkg

/* logic/lbd_pwm_if.sv */
// Carrier between the brightness path and the output waveform generator.
interface lbd_pwm_if;
	logic [15:0] period;
	logic [15:0] duty;
	logic [3:0]  resolution;
	logic        direct;
	logic        direct_level;
	logic [5:0]  chan_enable;
	logic [5:0]  led;

	modport src (output period, output duty, output resolution, output direct,
		output direct_level, output chan_enable, input led);
	modport gen (input period, input duty, input resolution, input direct,
		input direct_level, input chan_enable, output led);
endinterface : lbd_pwm_if

/* logic/lbd_pwm_gen.sv */
// Output waveform generator running on the block's own timebase.
module lbd_pwm_gen
	import lbd_pkg::*;
(
	input  wire logic clock,
	input  wire logic resetn,
	lbd_pwm_if.gen    pw
);

	logic [15:0] cnt_q;
	logic [15:0] thr_q;
	logic        full_q;
	logic [15:0] last_q;
	logic [5:0]  led_q;
	logic [15:0] duty_mask;
	logic [15:0] duty_cut;
	logic [31:0] thr_prod;
	logic        wrap;
	logic        on_now;

	// Duty is cut down to the resolution of the selected rate.
	assign duty_mask = 16'(DUTY_FULL << (5'd16 - 5'(pw.resolution)));
	assign duty_cut  = pw.duty & duty_mask;
	assign thr_prod  = 32'(pw.period) * 32'(duty_cut);
	assign wrap      = (cnt_q >= last_q);
	assign on_now    = full_q || (cnt_q < thr_q);

	// New period and duty take effect only at the wrap, so no runt pulse is emitted.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cnt_q  <= 16'h0000;
			thr_q  <= 16'h0000;
			full_q <= 1'b0;
			last_q <= 16'h0000;
		end else if (wrap) begin
			cnt_q  <= 16'h0000;
			thr_q  <= thr_prod[31:16];
			full_q <= (pw.duty == DUTY_FULL);
			last_q <= 16'(pw.period - 16'h0001);
		end else begin
			cnt_q <= 16'(cnt_q + 16'h0001);
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			led_q <= 6'h00;
		end else if (pw.direct) begin
			led_q <= pw.chan_enable & {CHANNELS{pw.direct_level}};
		end else begin
			led_q <= pw.chan_enable & {CHANNELS{on_now}};
		end
	end

	assign pw.led = led_q;

endmodule : lbd_pwm_gen

/* logic/lbd_dimming_ctrl.sv */
// Brightness source selection, dimming scheme mapping and current/rate decode.
module lbd_dimming_ctrl
	import lbd_pkg::*;
#(
	parameter int unsigned WINDOW_LOG2 = WINDOW_LOG2_DEF
) (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        pwm_in,
	input  wire logic        pass_through,
	input  wire logic [1:0]  brightness_source_select,
	input  wire logic [7:0]  brightness_level,
	input  wire logic [1:0]  dimming_scheme,
	input  wire logic [6:0]  hybrid_switch_point,
	input  wire logic [5:0]  channel_enable,
	input  wire logic [3:0]  dimming_rate_code,
	input  wire logic        dimming_rate_from_resistor,
	input  wire logic [4:0]  rate_set_resistor,
	input  wire logic        level_from_resistor,
	input  wire logic [7:0]  level_set_resistor,
	input  wire logic [2:0]  current_range_code,
	input  wire logic [11:0] current_fine_code,
	output logic      [5:0]  led_pwm,
	output logic      [11:0] current_code,
	output logic      [15:0] input_duty,
	output logic      [15:0] dimming_freq_hz,
	output logic      [3:0]  dimming_resolution,
	output logic      [15:0] full_scale_ua,
	output logic             follow_input
);

	// ==========================================================================
	// Input pin synchroniser
	// ==========================================================================
	logic pwm_s1_q;
	logic pwm_s2_q;
	logic pwm_s3_q;
	logic pwm_lvl_q;

	// A level is accepted once the second and third stages agree, which rejects
	// a single-cycle metastable settle from reaching the duty counter.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pwm_s1_q  <= 1'b0;
			pwm_s2_q  <= 1'b0;
			pwm_s3_q  <= 1'b0;
			pwm_lvl_q <= 1'b0;
		end else begin
			pwm_s1_q <= pwm_in;
			pwm_s2_q <= pwm_s1_q;
			pwm_s3_q <= pwm_s2_q;
			if (pwm_s2_q == pwm_s3_q) begin
				pwm_lvl_q <= pwm_s3_q;
			end
		end
	end

	// ==========================================================================
	// Duty measurement
	// ==========================================================================
	localparam logic [15:0] WIN_LAST  = 16'((32'h1 << WINDOW_LOG2) - 32'h1);
	localparam logic [4:0]  WIN_SHIFT = 5'(DUTY_W - WINDOW_LOG2);
	localparam logic [16:0] WIN_FULL  = 17'(32'h1 << WINDOW_LOG2);

	logic [15:0] win_q;
	logic [16:0] high_q;
	logic [15:0] duty_q;
	logic [16:0] high_total;
	logic        win_end;
	logic [15:0] duty_meas;

	// High time is counted over a fixed window, so no divider is needed and a
	// slow input only lengthens the update interval to one window.
	assign win_end    = (win_q == WIN_LAST);
	assign high_total = 17'(high_q + 17'(pwm_lvl_q));
	// A window that is high throughout would wrap to zero after the shift, so it saturates.
	assign duty_meas  = (high_total >= WIN_FULL) ? DUTY_FULL :
		16'(high_total[15:0] << WIN_SHIFT);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			win_q  <= 16'h0000;
			high_q <= 17'h00000;
			duty_q <= 16'h0000;
		end else if (win_end) begin
			win_q  <= 16'h0000;
			high_q <= 17'h00000;
			duty_q <= duty_meas;
		end else begin
			win_q  <= 16'(win_q + 16'h0001);
			high_q <= high_total;
		end
	end

	// ==========================================================================
	// Source selection and curve shaper stage
	// ==========================================================================
	logic [15:0] shaped_q;
	logic [15:0] bright_q;
	logic [15:0] pre_shaper;
	logic [15:0] post_shaper;

	assign pre_shaper =
		(brightness_source_select == SRC_INPUT_X_LEVEL) ?
			lbd_scale_by_level(duty_q, brightness_level) :
		(brightness_source_select == SRC_LEVEL) ?
			{brightness_level, brightness_level} :
			duty_q;
	assign post_shaper = (brightness_source_select == SRC_SHAPED_X_LEVEL) ?
		lbd_scale_by_level(shaped_q, brightness_level) : shaped_q;

	// The shaper is a straight register stage here; the curve itself lives elsewhere.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			shaped_q <= 16'h0000;
			bright_q <= 16'h0000;
		end else begin
			shaped_q <= pre_shaper;
			bright_q <= post_shaper;
		end
	end

	// ==========================================================================
	// Dimming scheme mapping
	// ==========================================================================
	logic [15:0] switch_level;
	logic        above_switch;
	logic [31:0] hyb_num;
	logic [15:0] hyb_duty;
	logic [11:0] cur_d;
	logic [15:0] duty_d;
	logic [11:0] cur_q;
	logic [15:0] pwm_duty_q;

	assign switch_level = lbd_pct_to_level(hybrid_switch_point);
	assign above_switch = (bright_q >= switch_level);
	assign hyb_num      = 32'({bright_q, 16'h0000}) - 32'(bright_q);
	assign hyb_duty     = (switch_level == 16'h0000) ? DUTY_FULL :
		16'(hyb_num / 32'(switch_level));

	// Below the switch point the current holds the switch level and PWM carries
	// the rest, so brightness stays continuous across the crossover.
	assign cur_d =
		(dimming_scheme == DIM_PWM_ONLY)     ? FINE_FULL :
		(dimming_scheme == DIM_CURRENT_ONLY) ? bright_q[15:4] :
		above_switch ? bright_q[15:4] : switch_level[15:4];
	assign duty_d =
		(dimming_scheme == DIM_PWM_ONLY)     ? bright_q :
		(dimming_scheme == DIM_CURRENT_ONLY) ? DUTY_FULL :
		above_switch ? DUTY_FULL : hyb_duty;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cur_q      <= 12'h000;
			pwm_duty_q <= 16'h0000;
		end else begin
			cur_q      <= cur_d;
			pwm_duty_q <= duty_d;
		end
	end

	// ==========================================================================
	// Dimming rate decode
	// ==========================================================================
	logic [19:0] rate_word;
	logic        follow_d;
	logic [15:0] freq_q;
	logic [3:0]  res_q;
	logic [15:0] period_q;
	logic        follow_q;
	logic [15:0] period_d;

	assign rate_word = dimming_rate_from_resistor ?
		lbd_rate_from_resistor(rate_set_resistor) :
		lbd_rate_from_code(dimming_rate_code);
	assign follow_d  = dimming_rate_from_resistor && (rate_set_resistor == ROW_FOLLOW_INPUT);
	assign period_d  = 16'(CLK_HZ / 32'(rate_word[15:0]));

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			freq_q   <= 16'h0000;
			res_q    <= 4'h0;
			period_q <= 16'h0001;
			follow_q <= 1'b0;
		end else begin
			freq_q   <= rate_word[15:0];
			res_q    <= rate_word[19:16];
			period_q <= period_d;
			follow_q <= follow_d;
		end
	end

	// ==========================================================================
	// Full-scale current decode
	// ==========================================================================
	logic [15:0] range_ua;
	logic [27:0] fine_prod;
	logic [15:0] fine_ua;
	logic [7:0]  res_ratio;
	logic [23:0] res_scaled;
	logic [15:0] fs_d;
	logic [15:0] fs_q;

	assign range_ua   = 16'(16'(lbd_range_ma(current_range_code)) * UA_PER_MA);
	assign fine_prod  = 28'(range_ua) * 28'(current_fine_code);
	assign fine_ua    = 16'(fine_prod / 28'(FINE_FULL));
	// A higher set resistor lowers the current; a zero reading falls back to nominal.
	assign res_ratio  = (level_set_resistor == 8'h00) ? RESISTOR_NOMINAL : level_set_resistor;
	assign res_scaled = (24'(fine_ua) * 24'(RESISTOR_NOMINAL)) / 24'(res_ratio);
	assign fs_d = !level_from_resistor ? fine_ua :
		(res_scaled > 24'(DUTY_FULL)) ? DUTY_FULL : res_scaled[15:0];

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fs_q <= 16'h0000;
		end else begin
			fs_q <= fs_d;
		end
	end

	// ==========================================================================
	// Output waveform generator
	// ==========================================================================
	lbd_pwm_if pw ();

	assign pw.period       = period_q;
	assign pw.duty         = pwm_duty_q;
	assign pw.resolution   = res_q;
	assign pw.direct       = pass_through || follow_q;
	assign pw.direct_level = pwm_lvl_q;
	assign pw.chan_enable  = channel_enable;

	lbd_pwm_gen u_gen (
		.clock  (clock),
		.resetn (resetn),
		.pw     (pw.gen)
	);

	assign led_pwm            = pw.led;
	assign current_code       = cur_q;
	assign input_duty         = duty_q;
	assign dimming_freq_hz    = freq_q;
	assign dimming_resolution = res_q;
	assign full_scale_ua      = fs_q;
	assign follow_input       = follow_q;

endmodule : lbd_dimming_ctrl

/* bench/lbd_dimming_properties.sv */
// Concurrent checks on the ports of the brightness and dimming block.
module lbd_dimming_properties
	import lbd_pkg::*;
(
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic        pwm_in,
	input wire logic        pass_through,
	input wire logic [1:0]  brightness_source_select,
	input wire logic [7:0]  brightness_level,
	input wire logic [1:0]  dimming_scheme,
	input wire logic [6:0]  hybrid_switch_point,
	input wire logic [5:0]  channel_enable,
	input wire logic [3:0]  dimming_rate_code,
	input wire logic        dimming_rate_from_resistor,
	input wire logic [4:0]  rate_set_resistor,
	input wire logic        level_from_resistor,
	input wire logic [2:0]  current_range_code,
	input wire logic [11:0] current_fine_code,
	input wire logic [5:0]  led_pwm,
	input wire logic [11:0] current_code,
	input wire logic [15:0] dimming_freq_hz,
	input wire logic [3:0]  dimming_resolution,
	input wire logic [15:0] full_scale_ua
);
	// ====
	// Assertions
	// ====
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	wire logic by_code = !dimming_rate_from_resistor;
	wire logic src_lvl = brightness_source_select == SRC_LEVEL && brightness_level == 8'h00;
	rate_low_a: assert property (by_code && dimming_rate_code == 4'h0 |=>
		{dimming_resolution, dimming_freq_hz} == {4'hB, 16'h12C8}) else $error("rate code 0 wrong");
	rate_gap_a: assert property (by_code && dimming_rate_code == 4'h9 |=>
		{dimming_resolution, dimming_freq_hz} == {4'h9, 16'h41BC}) else $error("rate code 9 wrong");
	rate_top_a: assert property (by_code && dimming_rate_code == 4'hF |=>
		{dimming_resolution, dimming_freq_hz} == {4'h8, 16'h9640}) else $error("rate code F wrong");
	rate_row_a: assert property (!by_code && rate_set_resistor == 5'h01 |=>
		{dimming_resolution, dimming_freq_hz} == {4'hC, 16'h0962}) else $error("row rate wrong");
	range_top_a: assert property (!level_from_resistor && current_fine_code == 12'hFFF
		&& current_range_code == 3'h7 |=> full_scale_ua == 16'hC350) else $error("range 7 wrong");
	range_low_a: assert property (!level_from_resistor && current_fine_code == 12'hFFF
		&& current_range_code == 3'h0 |=> full_scale_ua == 16'h1388) else $error("range 0 wrong");
	copy_level_a: assert property ((pass_through && $stable(pwm_in)
		&& $stable(channel_enable))[*8] |-> led_pwm == (channel_enable & {6{pwm_in}}))
		else $error("pass-through copy wrong");
	pwm_full_a: assert property ((dimming_scheme == DIM_PWM_ONLY)[*5]
		|-> current_code == 12'hFFF) else $error("pwm-only current not full");
	level_zero_a: assert property ((src_lvl && dimming_scheme == DIM_CURRENT_ONLY)[*5]
		|-> current_code == 12'h000) else $error("current-only zero wrong");
	hybrid_below_a: assert property ((src_lvl && dimming_scheme == 2'h2
		&& hybrid_switch_point == 7'h32)[*5] |-> current_code == 12'h7FF)
		else $error("hybrid below switch wrong");
	cover property (pass_through && pwm_in);
	cover property (dimming_scheme == 2'h2);
	cover property (dimming_rate_from_resistor);
endmodule : lbd_dimming_properties

/* bench/lbd_host_model.sv */
// Host-side source of the external PWM pin, 16-cycle period.
module lbd_host_model (
	input  wire logic       clock,
	input  wire logic [4:0] high_cycles,
	output logic            pwm_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] phase_q = 4'h0;
	initial pwm_in = 1'b0;
	// The pin moves just after the edge so the block never samples it mid-change.
	always @(posedge clock) begin
		phase_q <= phase_q + 4'h1;
		pwm_in  <= #1 ({1'b0, phase_q} < high_cycles);
	end
endmodule : lbd_host_model

/* bench/testbench.sv */
// Self-checking bench of the brightness and dimming block.
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench;
	import lbd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock = 1'b0;
	logic        resetn = 1'b0;
	logic        pwm_in;
	logic        pass_through = 1'b0;
	logic [1:0]  brightness_source_select = 2'h0;
	logic [7:0]  brightness_level = 8'h00;
	logic [1:0]  dimming_scheme = 2'h1;
	logic [6:0]  hybrid_switch_point = 7'h00;
	logic [5:0]  channel_enable = 6'h3F;
	logic [3:0]  dimming_rate_code = 4'h0;
	logic        dimming_rate_from_resistor = 1'b0;
	logic [4:0]  rate_set_resistor = 5'h00;
	logic        level_from_resistor = 1'b0;
	logic [7:0]  level_set_resistor = 8'h80;
	logic [2:0]  current_range_code = 3'h0;
	logic [11:0] current_fine_code = 12'hFFF;
	logic [4:0]  high_cycles = 5'h08;
	logic [5:0]  led_pwm;
	logic [11:0] current_code;
	logic [15:0] input_duty;
	logic [15:0] dimming_freq_hz;
	logic [3:0]  dimming_resolution;
	logic [15:0] full_scale_ua;
	logic        follow_input;
	logic        in_band = 1'b0;
	int          mismatches = 0;
	int          checks_done = 0;
	int          cycles = 0;
	int          highs;
	integer      seed;
	logic [19:0] exp_q[$];
	logic [19:0] got;
	logic [19:0] want;
	int          id_q[$];
	event        obs_ev;
	logic [15:0] freq_t [16] = '{16'h12C8, 16'h177A, 16'h1C2C, 16'h20DE, 16'h2590, 16'h2EF4,
		16'h33A6, 16'h3858, 16'h3D0A, 16'h41BC, 16'h466E, 16'h4B20, 16'h5DE8, 16'h70B0,
		16'h8378, 16'h9640};
	logic [3:0]  res_t [16] = '{4'hB, 4'hA, 4'hA, 4'hA, 4'hA, 4'h9, 4'h9, 4'h9, 4'h9, 4'h9,
		4'h9, 4'h9, 4'h8, 4'h8, 4'h8, 4'h8};
	logic [15:0] ua_t [8] = '{16'h1388, 16'h2710, 16'h3A98, 16'h4E20, 16'h59D8, 16'h61A8,
		16'h7530, 16'hC350};

	// A short window keeps the duty measurement to 256 cycles.
	lbd_dimming_ctrl #(.WINDOW_LOG2(8)) DUT (.clock, .resetn, .pwm_in, .pass_through,
		.brightness_source_select, .brightness_level, .dimming_scheme, .hybrid_switch_point,
		.channel_enable, .dimming_rate_code, .dimming_rate_from_resistor, .rate_set_resistor,
		.level_from_resistor, .level_set_resistor, .current_range_code, .current_fine_code,
		.led_pwm, .current_code, .input_duty, .dimming_freq_hz, .dimming_resolution,
		.full_scale_ua, .follow_input);
	lbd_host_model u_host (.clock, .high_cycles, .pwm_in);

	initial forever #4 clock = ~clock;

	// ====
	// Tasks
	// ====
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step

	task automatic note(input int id, input logic [19:0] v);
		id_q.push_back(id);
		exp_q.push_back(v);
		->obs_ev;
	endtask : note

	task automatic run_case(input logic [1:0] s, input logic [7:0] l, input logic [1:0] m,
		input logic [6:0] p, input logic [11:0] e);
		brightness_source_select = s;
		brightness_level = l;
		dimming_scheme = m;
		hybrid_switch_point = p;
		step(6);
		note(2, {8'h00, e});
	endtask : run_case

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	function automatic logic [19:0] seen(input int id);
		case (id)
			0: return {dimming_resolution, dimming_freq_hz};
			1: return {4'h0, full_scale_ua};
			2: return {8'h00, current_code};
			3: return {4'h0, input_duty};
			4: return {14'h0, led_pwm};
			6: return {19'h0, follow_input};
			default: return {19'h0, in_band};
		endcase
	endfunction : seen

	// ====
	// Watcher and timeout
	// ====
	initial forever begin
		@(obs_ev);
		while (exp_q.size() > 0) begin
			got  = seen(id_q.pop_front());
			want = exp_q.pop_front();
			`CHK(got, want)
		end
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			report_and_stop();
		end
	end

	// ====
	// Scenarios
	// ====
	initial begin
		seed = 32'h3B68;
		step(5);
		resetn = 1'b1;
		for (int i = 0; i < 16; i++) begin
			dimming_rate_code = 4'(i);
			rate_set_resistor = 5'($random(seed));
			step(2);
			note(0, {res_t[i], freq_t[i]});
		end
		dimming_rate_from_resistor = 1'b1;
		dimming_rate_code = 4'($random(seed));
		rate_set_resistor = 5'h01;
		step(2);
		note(0, {4'hC, 16'h0962});
		rate_set_resistor = 5'h19;
		step(2);
		note(6, 20'h00001);
		$display("test rate finished");
		for (int i = 0; i < 8; i++) begin
			current_range_code = 3'(i);
			level_from_resistor = i[0];
			level_set_resistor = i[0] ? RESISTOR_NOMINAL : 8'($random(seed));
			step(2);
			note(1, {4'h0, ua_t[i]});
		end
		$display("test current finished");
		step(800);
		note(3, 20'h08000);
		note(2, 20'h00800);
		run_case(2'h1, 8'hFF, 2'h1, 7'h00, 12'h7FF);
		run_case(2'h3, 8'hFF, 2'h1, 7'h00, 12'h7FF);
		run_case(2'h3, 8'h00, 2'h1, 7'h00, 12'h000);
		run_case(2'h1, 8'h00, 2'h1, 7'h00, 12'h000);
		run_case(2'h2, 8'h00, 2'h1, 7'h00, 12'h000);
		run_case(2'h2, 8'h00, 2'h0, 7'h00, 12'hFFF);
		run_case(2'h2, 8'h00, 2'h2, 7'h32, 12'h7FF);
		run_case(2'h2, 8'h00, 2'h2, 7'h00, 12'h000);
		run_case(2'h2, 8'hFF, 2'h3, 7'h64, 12'hFFF);
		high_cycles = 5'h10;
		step(800);
		note(3, 20'h0FFFF);
		$display("test path finished");
		pass_through = 1'b1;
		for (int i = 0; i < 4; i++) begin
			channel_enable = 6'($random(seed));
			brightness_source_select = 2'(i);
			high_cycles = i[0] ? 5'h10 : 5'h00;
			step(12);
			note(4, {14'h0, channel_enable & {6{i[0]}}});
		end
		$display("test direct finished");
		pass_through = 1'b0;
		channel_enable = 6'h3F;
		dimming_rate_from_resistor = 1'b0;
		dimming_rate_code = 4'hF;
		// A mid-run reset restarts the output counter, so the long rate code 0 period
		// latched just after the first reset cannot delay the new rate past the measurement.
		resetn = 1'b0;
		step(2);
		resetn = 1'b1;
		run_case(2'h2, 8'h80, 2'h0, 7'h00, 12'hFFF);
		dimming_rate_from_resistor = 1'b0;
		dimming_rate_code = 4'hF;
		highs = 0;
		// Two full periods pass first, since duty is only taken up at a wrap.
		step(6600);
		for (int i = 0; i < 3249; i++) begin
			highs += led_pwm[0];
			step(1);
		end
		in_band = highs > 1500 && highs < 1750;
		note(5, 20'h00001);
		$display("test timebase finished");
		step(2);
		report_and_stop();
	end
endmodule : testbench

bind lbd_dimming_ctrl lbd_dimming_properties u_props (.clock, .resetn, .pwm_in, .pass_through,
	.brightness_source_select, .brightness_level, .dimming_scheme, .hybrid_switch_point,
	.channel_enable, .dimming_rate_code, .dimming_rate_from_resistor, .rate_set_resistor,
	.level_from_resistor, .current_range_code, .current_fine_code, .led_pwm, .current_code,
	.dimming_freq_hz, .dimming_resolution, .full_scale_ua);
